// ===== rtl/mcu_reset_sequencer.sv
// How it works
// [RULE1] Bit 2 of the converter control register disables the main oscillator when 1.
// [RULE2] That bit only acts when the oscillator safeguard factory option is on.
// [RULE3] With the detector option on, reset is held as long as the supply is low.
// [RULE4] The detector uses the rising threshold while low and the falling one while high.
// [RULE5] During a low-voltage reset the reset pin is actively driven low.
// [RULE6] Reset causes are the pin, a watchdog expiry and the low-voltage detector.
// [RULE7] After a reset the sequencer waits 2048 cycles, then fetches the vector for 2.
// [RULE8] Reset clears the call stack and loads the program counter with 0FFEh.
// [RULE9] Reset puts the core in non-maskable-interrupt mode until it returns.
// [RULE10] A low pin holds reset in any mode for as long as it stays low.
// [RULE11] Any pin pulse is stretched by the full 2048-cycle delay.
// [RULE12] A pin reset stops the core, forces pulled-up inputs and restarts the oscillator.
// [RULE13] In stop mode a pin reset starts the oscillator and forces pulled-up inputs too.
// [RULE14] A watchdog expiry runs the same sequence as a pin reset.
// [RULE15] A watchdog reset drives the pin low only briefly.
// [RULE16] The delay count runs on the backup oscillator until the main one takes over.
// [RULE17] Any active cause restarts the count; release is synchronous after it ends.
`timescale 1ns/1ps
`default_nettype none

module mcu_reset_sequencer
    import rstseq_pkg::*;
#(
    parameter int unsigned DELAY = DELAY_CYCLES,
    parameter int unsigned FETCH = FETCH_CYCLES,
    parameter int unsigned WDG_PULSE = WDG_PIN_CYCLES
) (
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   reset_pin_in,
    output logic                        reset_pin_out,
    output logic                        reset_pin_oe,
    input  wire logic                   watchdog_expiry,
    input  wire rstseq_pkg::supply_in_s supply_in,
    output logic                        main_osc_enable,
    output logic                        delay_clk_main_sel,
    output rstseq_pkg::core_ctrl_s      core_ctrl
);

    import rstseq_pkg::*;

    localparam int unsigned CW = $clog2(DELAY + 1);
    localparam int unsigned WW = $clog2(WDG_PULSE + 1);

    initial begin
        if (DELAY < 2 || FETCH < 1 || WDG_PULSE < 1 || WDG_PULSE >= DELAY) begin
            $error("mcu_reset_sequencer: unsupported timing parameters");
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic       pin_low_s;
    logic [4:0] sup_s;
    logic       pin_raw_s;

    sync2 #(.WIDTH(1), .INIT(1'b1)) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (reset_pin_in),
        .q       (pin_raw_s)
    );

    // Comparators start as "supply low" so a cold start holds reset
    sync2 #(.WIDTH(5), .INIT(5'h00)) u_sup_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (supply_in),
        .q       (sup_s)
    );

    supply_in_s sup;
    assign sup       = supply_in_s'(sup_s);
    assign pin_low_s = ~pin_raw_s;

    ////////////////////////////////////////////////////////////////////////////
    // Low-voltage detector with hysteresis

    logic uv_low_r;
    logic uv_low_nxt;
    logic uv_req;

    assign uv_low_nxt = uv_low_r ? ~sup.above_rising_threshold          // [RULE4]
                                 : ~sup.above_falling_threshold;       // [RULE4]
    assign uv_req = sup.low_voltage_detector_option & uv_low_r;       // [RULE3]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            uv_low_r <= 1'b1;
        end else begin
            uv_low_r <= uv_low_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequence

    seq_state_e      state_r;
    seq_state_e      state_nxt;
    logic [CW-1:0]   cnt_r;
    logic [CW-1:0]   cnt_nxt;
    logic            any_req;
    logic            delay_done;
    logic            fetch_done;

    // Our own watchdog pulse reads back on the pin; it restarts the count and also sets the pin cause flag
    assign any_req    = pin_low_s | watchdog_expiry | uv_req;       // [RULE6] [RULE10] [RULE14]
    assign delay_done = (cnt_r == CW'(DELAY - 1));
    assign fetch_done = (cnt_r == CW'(FETCH - 1));

    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + CW'(1);
        if (any_req) begin
            state_nxt = ST_HOLD;                                    // [RULE17]
            cnt_nxt   = '0;
        end else begin
            case (state_r)
                ST_HOLD: begin
                    state_nxt = ST_DELAY;                           // [RULE11]
                    cnt_nxt   = '0;
                end
                ST_DELAY: begin
                    if (delay_done) begin
                        state_nxt = ST_FETCH;                       // [RULE7]
                        cnt_nxt   = '0;
                    end
                end
                ST_FETCH: begin
                    if (fetch_done) begin
                        state_nxt = ST_RUN;                         // [RULE7]
                        cnt_nxt   = '0;
                    end
                end
                ST_RUN: begin
                    cnt_nxt = '0;
                end
                default: begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = '0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_HOLD;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset pin drive

    logic [WW-1:0] wdg_cnt_r;
    logic [WW-1:0] wdg_cnt_nxt;
    logic          pin_drive_nxt;

    assign wdg_cnt_nxt = watchdog_expiry ? WW'(WDG_PULSE)           // [RULE15]
                       : (wdg_cnt_r != '0) ? wdg_cnt_r - WW'(1) : '0;
    assign pin_drive_nxt = uv_req | (wdg_cnt_nxt != '0);            // [RULE5] [RULE15]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdg_cnt_r     <= '0;
            reset_pin_oe  <= 1'b0;
            reset_pin_out <= 1'b0;
        end else begin
            wdg_cnt_r     <= wdg_cnt_nxt;
            reset_pin_oe  <= pin_drive_nxt;
            reset_pin_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB registers

    logic [7:0] conv_r;
    logic [2:0] cause_r;
    logic       acc;
    logic       wr_acc;
    logic       hit_conv;
    logic       hit_status;
    logic       hit_cause;
    logic       hit_any;
    logic       in_reset;
    logic [7:0] status_w;
    logic [2:0] cause_set;
    logic [2:0] cause_nxt;
    logic [31:0] rd_mux;

    assign acc        = psel & penable & ~pready;
    // Writes land on the edge that completes the access
    assign wr_acc     = psel & penable & pready & pwrite;
    assign hit_conv   = (paddr == CONV_OFS);
    assign hit_status = (paddr == STATUS_OFS);
    assign hit_cause  = (paddr == CAUSE_OFS);
    assign hit_any    = hit_conv | hit_status | hit_cause;
    assign in_reset   = (state_r != ST_RUN);

    assign cause_set[CAUSE_PIN_BIT] = pin_low_s;
    assign cause_set[CAUSE_WDG_BIT] = watchdog_expiry;
    assign cause_set[CAUSE_UV_BIT]  = uv_req;
    // Write-one-to-clear; a cause seen in the same cycle survives
    assign cause_nxt = (cause_r & ~((wr_acc & hit_cause) ? pwdata[2:0] : 3'h0)) | cause_set;

    always_comb begin
        status_w = 8'h00;
        status_w[ST_ACTIVE_BIT]  = in_reset;
        status_w[ST_CLKMAIN_BIT] = delay_clk_main_sel;
        status_w[ST_OSCEN_BIT]   = main_osc_enable;
        status_w[ST_UVLOW_BIT]   = uv_low_r;
        status_w[ST_STATE_LSB +: 2] = state_r;
    end

    assign rd_mux = hit_conv   ? {24'h000000, conv_r}
                  : hit_status ? {24'h000000, status_w}
                  : hit_cause  ? {29'h00000000, cause_r}
                  : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv_r <= CONV_RESET;
        end else if (in_reset) begin
            conv_r <= CONV_RESET;                                   // [RULE12]
        end else if (wr_acc && hit_conv) begin
            conv_r <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_r <= 3'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            cause_r <= cause_nxt;
            pready  <= acc;
            pslverr <= acc & ~hit_any;
            prdata  <= (acc && !pwrite) ? rd_mux : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator and core control

    logic       osc_en_nxt;
    core_ctrl_s core_nxt;

    assign osc_en_nxt = in_reset                                     // [RULE12] [RULE13]
                      | ~(sup.safeguard_enable_option & conv_r[OSC_OFF_BIT]); // [RULE1] [RULE2]

    always_comb begin
        core_nxt                 = '0;
        core_nxt.core_reset_n    = (state_nxt == ST_RUN);           // [RULE17]
        core_nxt.io_pullup_force = (state_nxt != ST_RUN);           // [RULE12] [RULE13]
        core_nxt.stack_clear     = (state_nxt == ST_FETCH);         // [RULE8]
        core_nxt.pc_load         = (state_nxt == ST_FETCH);         // [RULE8]
        core_nxt.nmi_mode_set    = (state_nxt == ST_FETCH);         // [RULE9]
        core_nxt.pc_value        = RESET_VECTOR;                    // [RULE8]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_osc_enable    <= 1'b1;
            delay_clk_main_sel <= 1'b0;
            core_ctrl          <= '{core_reset_n: 1'b0, io_pullup_force: 1'b1,
                                    stack_clear: 1'b0, pc_load: 1'b0,
                                    nmi_mode_set: 1'b0, pc_value: RESET_VECTOR};
        end else begin
            main_osc_enable    <= osc_en_nxt;
            delay_clk_main_sel <= sup.main_osc_running;             // [RULE16]
            core_ctrl          <= core_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [CW:0] run_gap_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_gap_r <= '0;
        end else if (any_req) begin
            run_gap_r <= '0;
        end else if (run_gap_r != '1) begin
            run_gap_r <= run_gap_r + (CW+1)'(1);
        end
    end

    a_osc_off_gated: assert property (                                         // [RULE2]
        (!in_reset && !sup.safeguard_enable_option) |=> main_osc_enable)
        else $error("oscillator disabled without safeguard option");

    a_osc_off_bit: assert property (                                           // [RULE1]
        (!in_reset && sup.safeguard_enable_option && conv_r[OSC_OFF_BIT])
        |=> !main_osc_enable)
        else $error("oscillator stays on with off bit set");

    a_uv_hold: assert property (                                               // [RULE3]
        uv_req |=> state_r == ST_HOLD)
        else $error("low supply did not hold reset");

    a_uv_hyst: assert property (                                               // [RULE4]
        (!uv_low_r && sup.above_falling_threshold) |=> !uv_low_r)
        else $error("detector tripped above falling threshold");

    a_uv_pin: assert property (                                                // [RULE5]
        uv_req |=> reset_pin_oe && !reset_pin_out)
        else $error("pin not driven low in low-voltage reset");

    a_delay_len: assert property (                                             // [RULE7] [RULE11]
        $rose(state_r == ST_FETCH) |-> run_gap_r == (CW+1)'(DELAY + 1))
        else $error("delay phase length wrong");

    a_fetch_len: assert property (                                             // [RULE7]
        ($rose(state_r == ST_FETCH) && !any_req) |=> state_r == ST_FETCH ##1
        (state_r == ST_RUN || $past(any_req)))
        else $error("fetch phase length wrong");

    a_vector_load: assert property (                                           // [RULE8] [RULE9]
        core_ctrl.pc_load |-> core_ctrl.stack_clear && core_ctrl.nmi_mode_set
        && core_ctrl.pc_value == 12'hFFE && !core_ctrl.core_reset_n)
        else $error("vector fetch outputs inconsistent");

    a_pin_holds: assert property (                                             // [RULE10]
        pin_low_s |=> !core_ctrl.core_reset_n && core_ctrl.io_pullup_force)
        else $error("low pin did not hold reset");

    a_wdg_pulse: assert property (                                             // [RULE15]
        watchdog_expiry ##1 (!watchdog_expiry && !uv_req) [*8] |=> !reset_pin_oe)
        else $error("watchdog pin pulse too long");

    a_wdg_restart: assert property (                                           // [RULE14]
        watchdog_expiry |=> state_r == ST_HOLD ##1 state_r == ST_DELAY || any_req)
        else $error("watchdog did not restart sequence");

    // Cause flags stand as the record of which reset the core came out of
    c_pin_reset: cover property (cause_r[CAUSE_PIN_BIT] && $rose(core_ctrl.core_reset_n));
    c_wdg_reset: cover property (cause_r[CAUSE_WDG_BIT] && $rose(core_ctrl.core_reset_n));
    c_uv_reset:  cover property (cause_r[CAUSE_UV_BIT] && $rose(core_ctrl.core_reset_n));
    c_osc_off:   cover property (!main_osc_enable);

endmodule

`default_nettype wire

// ===== rtl/rstseq_pkg.sv
package rstseq_pkg;

    // Reset sequence timing, in internal clock cycles
    localparam int unsigned DELAY_CYCLES   = 2048;
    localparam int unsigned FETCH_CYCLES   = 2;
    localparam int unsigned WDG_PIN_CYCLES = 8;

    localparam logic [11:0] RESET_VECTOR = 12'hFFE;

    // APB register map (byte addresses)
    localparam logic [7:0] CONV_OFS   = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] CAUSE_OFS  = 8'h08;

    localparam logic [7:0] CONV_RESET  = 8'h40;
    localparam int unsigned OSC_OFF_BIT = 2;

    // Reset cause register fields
    localparam int unsigned CAUSE_PIN_BIT = 0;
    localparam int unsigned CAUSE_WDG_BIT = 1;
    localparam int unsigned CAUSE_UV_BIT  = 2;

    // Status register fields
    localparam int unsigned ST_ACTIVE_BIT  = 0;
    localparam int unsigned ST_CLKMAIN_BIT = 1;
    localparam int unsigned ST_OSCEN_BIT   = 2;
    localparam int unsigned ST_UVLOW_BIT   = 3;
    localparam int unsigned ST_STATE_LSB   = 4;

    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_DELAY = 2'b01,
        ST_FETCH = 2'b10,
        ST_RUN   = 2'b11
    } seq_state_e;

    // Supply comparators and factory options, all asynchronous
    typedef struct packed {
        logic above_rising_threshold;
        logic above_falling_threshold;
        logic low_voltage_detector_option;
        logic safeguard_enable_option;
        logic main_osc_running;
    } supply_in_s;

    // Commands to the core
    typedef struct packed {
        logic        core_reset_n;
        logic        io_pullup_force;
        logic        stack_clear;
        logic        pc_load;
        logic        nmi_mode_set;
        logic [11:0] pc_value;
    } core_ctrl_s;

endpackage

// ===== rtl/sync2.sv
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;

    initial begin
        if (WIDTH < 1) begin
            $error("sync2: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= INIT;
            q      <= INIT;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

`default_nettype wire

// ===== verification/board_reset.sv
`timescale 1ns/1ps
`default_nettype none

module board_reset (
    input  wire logic pclk,
    input  wire logic reset_pin_out,
    input  wire logic reset_pin_oe,
    input  wire logic board_hold_n,
    output logic      reset_pin_in,
    output int        pulse_len
);
    int run_len = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Open-drain wire with pull-up; any party pulling low wins
    assign reset_pin_in = (reset_pin_oe ? reset_pin_out : 1'b1) & board_hold_n;

    ////////////////////////////////////////////////////////////////////////////
    // Width of the last low pulse driven by the device
    initial pulse_len = 0;
    always @(posedge pclk) begin
        if (reset_pin_oe && !reset_pin_out) begin
            run_len <= run_len + 1;
        end else begin
            if (run_len != 0) begin
                pulse_len <= run_len;
            end
            run_len <= 0;
        end
    end
endmodule

`default_nettype wire

// ===== verification/mcu_reset_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none

module mcu_reset_sequencer_bench;
    import rstseq_pkg::*;
    localparam int unsigned DLY = 16;
    // Supply sync plus our own pin drive reading back through the pin sync
    localparam int unsigned UV_EXTRA = 3;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] rdata;
        logic        err;
    } apb_row_s;

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        reset_pin_in, reset_pin_out, reset_pin_oe, board_hold_n, err;
    logic        watchdog_expiry, main_osc_enable, delay_clk_main_sel;
    supply_in_s  sup;
    core_ctrl_s  core_ctrl;
    int          pulse_len;
    int          fails = 0;
    int          compares = 0;
    apb_row_s    rows [8] = '{
        '{1'b0, 8'h00, 32'h0, 32'h40, 1'b0},
        '{1'b1, 8'h00, 32'h04, 32'h0, 1'b0},
        '{1'b0, 8'h00, 32'h0, 32'h04, 1'b0},
        '{1'b1, 8'h04, 32'hFF, 32'h0, 1'b0},
        '{1'b0, 8'h04, 32'h0, 32'h36, 1'b0},
        '{1'b1, 8'h08, 32'hFFFFFFFF, 32'h0, 1'b0},
        '{1'b0, 8'h08, 32'h0, 32'h0, 1'b0},
        '{1'b0, 8'h0C, 32'h0, 32'h0, 1'b1}
    };

    mcu_reset_sequencer #(.DELAY(DLY)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
        .reset_pin_oe(reset_pin_oe), .watchdog_expiry(watchdog_expiry), .supply_in(sup),
        .main_osc_enable(main_osc_enable), .delay_clk_main_sel(delay_clk_main_sel),
        .core_ctrl(core_ctrl)
    );

    board_reset board (
        .pclk(pclk), .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe),
        .board_hold_n(board_hold_n), .reset_pin_in(reset_pin_in), .pulse_len(pulse_len)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("Checks made: %0d, mismatches: %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Master holds everything until pready is sampled high
    task automatic apb(input apb_row_s r, output logic [31:0] rdat, output logic serr);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= r.wr;
        paddr <= r.addr;
        pwdata <= r.wdata;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (k >= 20) begin
            fails++;
            finish_test();
        end
    endtask

    // Runs until the core is released; extra covers known hold time before the count
    task automatic seq_check(input int extra);
        int n;
        int f;
        n = 0;
        f = 0;
        // Reset lands one edge after the request; look past it first
        @(posedge pclk);
        chk("rst_entered", 32'h0, core_ctrl.core_reset_n);
        while (core_ctrl.core_reset_n !== 1'b1 && n < 300) begin
            @(posedge pclk);
            n++;
            if (core_ctrl.pc_load === 1'b1) begin
                f++;
                chk("fetch_cmds", 32'h7, {core_ctrl.stack_clear, core_ctrl.nmi_mode_set,
                    core_ctrl.pc_value === RESET_VECTOR});
            end
        end
        if (n >= 300) begin
            fails++;
            finish_test();
        end
        chk("fetch_len", FETCH_CYCLES, 32'(f));
        compares++;
        if (n < DLY + FETCH_CYCLES + extra + 1 || n > DLY + FETCH_CYCLES + extra + 5) begin
            fails++;
            $display("ERROR seq_len expected %0d seen %0d", DLY + FETCH_CYCLES + extra + 3, n);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        board_hold_n = 1'b1;
        watchdog_expiry = 1'b0;
        sup = 5'b00100;
        cyc(3);
        presetn <= 1'b1;
        chk("pc_value", RESET_VECTOR, core_ctrl.pc_value);
        chk("io_pullup", 32'h1, io_pullup());
        chk("delay_sel", 32'h0, delay_clk_main_sel);
        cyc(10);
        chk("core_rst_low", 32'h0, core_ctrl.core_reset_n);
        chk("pin_oe_uv", 32'h1, reset_pin_oe & ~reset_pin_out);
        sup.above_falling_threshold <= 1'b1;
        cyc(10);
        chk("core_rst_hyst", 32'h0, core_ctrl.core_reset_n);
        sup.above_rising_threshold <= 1'b1;
        sup.main_osc_running <= 1'b1;
        seq_check(UV_EXTRA);
        chk("delay_sel_main", 32'h1, delay_clk_main_sel);
        $display("Test power_up done");

        foreach (rows[i]) begin
            apb(rows[i], rd, err);
            chk("pslverr", rows[i].err, err);
            if (!rows[i].wr) begin
                chk("prdata", rows[i].rdata, rd);
            end
        end
        apb('{1'b1, 8'h00, 32'h04, 32'h0, 1'b0}, rd, err);
        cyc(4);
        chk("osc_no_safeguard", 32'h1, main_osc_enable);
        sup.safeguard_enable_option <= 1'b1;
        cyc(5);
        chk("osc_off", 32'h0, main_osc_enable);
        $display("Test registers done");

        for (int len = 3; len < 60; len += 37) begin
            board_hold_n <= 1'b0;
            cyc(len);
            if (len > DLY) begin
                chk("pin_hold", 32'h0, core_ctrl.core_reset_n);
                chk("osc_restart", 32'h1, main_osc_enable);
                chk("io_pullup_pin", 32'h1, io_pullup());
            end
            board_hold_n <= 1'b1;
            seq_check(0);
        end
        apb('{1'b0, 8'h00, 32'h0, 32'h0, 1'b0}, rd, err);
        chk("conv_after_rst", 32'h40, rd);
        $display("Test pin_reset done");

        watchdog_expiry <= 1'b1;
        cyc(1);
        watchdog_expiry <= 1'b0;
        seq_check(WDG_PIN_CYCLES);
        chk("wdg_pulse", WDG_PIN_CYCLES, 32'(pulse_len));
        $display("Test watchdog done");

        sup.above_rising_threshold <= 1'b0;
        cyc(10);
        chk("run_above_fall", 32'h1, core_ctrl.core_reset_n);
        sup.above_falling_threshold <= 1'b0;
        cyc(10);
        chk("drop_reset", 32'h0, core_ctrl.core_reset_n);
        chk("drop_pin_oe", 32'h1, reset_pin_oe & ~reset_pin_out);
        sup.above_falling_threshold <= 1'b1;
        sup.above_rising_threshold <= 1'b1;
        seq_check(UV_EXTRA);
        $display("Test voltage_drop done");
        finish_test();
    end

    function automatic logic io_pullup();
        return core_ctrl.io_pullup_force;
    endfunction
endmodule

`default_nettype wire
